// ===== hw/dcce_pkg.sv
/*
 * Shared constants and types for the daisy-chain command engine.
 * Assumes byte-level framing (preamble, stop, Manchester decode) is done
 * outside; the engine sees one byte per rx_valid pulse.
 */
// Function
// - Address byte returned to host equals last device address plus one.
// - Valid assignment clears unlock bit; locked device ignores assignment.
// - Assignment packet is 57h, 00h, address byte; store it, send plus one.
// - Broadcast write stores 16-bit value; invalid register address is ignored.
// - Write commits on matching PEC byte, or at packet end without PEC.
// - PEC mismatch skips the write yet forwards the packet with only the alive byte changed.
// - Write PEC covers command, register address, data low, data high.
// - Write PEC mismatch sets the PEC alert; unicast only in target.
// - Broadcast write is 02h, address, data, PEC, alive; passed through.
// - Unicast write command carries target address above 0b100.
// - Broadcast read returns every word; nearest device arrives last.
// - Read PEC mismatch sets alert in data-check byte and status; on a presence poll the code sets only the status bit.
// - Manchester error during read switches to pure pass-through.
// - Device sends address, own word, received words, check, PEC, alive.
// - Data-check position follows from first address and own address.
// - Unicast read: target replaces fill with its word, bumps alive.
// - Unicast read command carries target address above 0b101.
// - Presence poll reads address register as 32 devices from zero.
// - No loopback before loopback bit set, so first assignment not returned.
// - Device ORs its own alert status into the data-check byte.
// - Broadcast commands increment alive byte, wrapping; excluded from PEC.
// - Down-stack path forwards everything, assignment byte included, unmodified.
// - Unicast commands for another address are merely passed along.
package dcce_pkg;

    // ************************************************
    // command encoding
    // ************************************************
    localparam logic [7:0] CMD_ASSIGN = 8'h57;
    localparam logic [7:0] CMD_BWR = 8'h02;
    localparam logic [7:0] CMD_BRD = 8'h03;
    localparam logic [7:0] CMD_POLL = 8'h01;
    localparam logic [2:0] UWR_LOW = 3'h4;
    localparam logic [2:0] URD_LOW = 3'h5;

    // ************************************************
    // byte positions inside a frame (0 = command)
    // ************************************************
    localparam logic [7:0] POS_ADDR = 8'h02;
    localparam logic [7:0] POS_LSB = 8'h02;
    localparam logic [7:0] POS_MSB = 8'h03;
    localparam logic [7:0] POS_WPEC = 8'h04;
    localparam logic [7:0] POS_WALIVE = 8'h05;
    localparam logic [7:0] POS_RD_INS = 8'h02;
    localparam logic [7:0] POS_RD_DC0 = 8'h04;
    localparam logic [7:0] POS_POLL_DC = 8'h41;
    localparam logic [7:0] POS_NONE = 8'hFF;
    localparam int DC_PEC_BIT = 7;

    // ************************************************
    // reset values and checksum
    // ************************************************
    localparam logic UNLOCK_RST = 1'b1;
    localparam logic [7:0] ADDR_REG_IDX = 8'h00;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [2:0] {
        K_NONE, K_ASSIGN, K_BWR, K_UWR, K_BRD, K_URD, K_POLL
    } dcce_kind_type;

    typedef struct packed {
        logic in_frame;
        logic [7:0] pos;
        dcce_kind_type kind;
        logic pass;
        logic shift;
        logic pec_bad;
        logic tx_acc;
        logic [7:0] ins_pos;
        logic [7:0] dc_pos;
        logic [7:0] rpec_pos;
        logic [7:0] regb;
        logic [15:0] data;
        logic [7:0] dly0;
        logic [7:0] dly1;
        logic [7:0] rx_crc;
        logic [7:0] tx_crc;
        logic [4:0] dev_addr;
        logic unlock;
        logic pec_alert;
        logic wr;
        logic tx_sof;
        logic tx_eof;
        logic tx_valid;
        logic tx_err;
        logic [7:0] tx_byte;
    } dcce_state_type;

endpackage

// ===== hw/dcce_crc8.sv
/*
 * One byte step of the packet checksum, MSB first, no reflection.
 * Purely combinational; the caller holds the running value.
 */
`timescale 1ns/1ns
module dcce_crc8
    import dcce_pkg::*;
(
    // running value and new byte
    input wire logic [7:0] crc_i,
    input wire logic [7:0] byte_i,
    // updated value
    output logic [7:0] crc_o
);
    always_comb begin
        logic [7:0] c;
        c = crc_i ^ byte_i;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        crc_o = c;
    end
endmodule

// ===== hw/dcce_down_path.sv
/*
 * Down-stack return path: one register stage, bytes never altered.
 * With loopback selected the up-stack output is turned back instead.
 */
`timescale 1ns/1ns
module dcce_down_path
    import dcce_pkg::*;
(
    // clock and synchronised reset
    input wire logic clk,
    input wire logic rs_n,
    // loopback select (top device only)
    input wire logic loopback_en,
    // up-stack output of this device
    input wire logic up_sof,
    input wire logic up_valid,
    input wire logic [7:0] up_byte,
    input wire logic up_eof,
    // from the device above
    input wire logic dn_rx_sof,
    input wire logic dn_rx_valid,
    input wire logic [7:0] dn_rx_byte,
    input wire logic dn_rx_eof,
    // toward the host
    output logic dn_tx_sof,
    output logic dn_tx_valid,
    output logic [7:0] dn_tx_byte,
    output logic dn_tx_eof
);
    typedef struct packed {
        logic sof;
        logic valid;
        logic [7:0] byte_v;
        logic eof;
    } dcce_dn_type;

    dcce_dn_type s, n;

    // until the loopback bit is set nothing turns back here
    always_comb begin
        n = loopback_en ? {up_sof, up_valid, up_byte, up_eof}
                        : {dn_rx_sof, dn_rx_valid, dn_rx_byte, dn_rx_eof};
    end // byte forwarded as received

    always_ff @(posedge clk or negedge rs_n) begin
        if (!rs_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dn_tx_sof = s.sof;
    assign dn_tx_valid = s.valid;
    assign dn_tx_byte = s.byte_v;
    assign dn_tx_eof = s.eof;

    a_down_plain: assert property (@(posedge clk) disable iff (!rs_n)
        (!loopback_en && dn_rx_valid) |=> dn_tx_valid
        && dn_tx_byte == $past(dn_rx_byte))
        else $error("down path altered a byte");
endmodule

// ===== hw/dcce_engine.sv
/*
 * Command engine of one chain device: decodes frames from the lower
 * receiver, updates address and registers, rewrites read streams and
 * drives the upper transmitter one cycle later, byte for byte.
 * Assumes rx_sof, rx_valid and rx_eof never share a cycle and that the
 * register map answers reg_rd_data and reg_addr_ok combinationally.
 */
`timescale 1ns/1ns
module dcce_engine
    import dcce_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // lower receiver byte stream
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic rx_code_err,
    // upper transmitter byte stream
    output logic tx_sof,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_eof,
    output logic tx_code_err,
    // down-stack path
    input wire logic loopback_en,
    input wire logic dn_rx_sof,
    input wire logic dn_rx_valid,
    input wire logic [7:0] dn_rx_byte,
    input wire logic dn_rx_eof,
    output logic dn_tx_sof,
    output logic dn_tx_valid,
    output logic [7:0] dn_tx_byte,
    output logic dn_tx_eof,
    // configuration and status
    input wire logic [4:0] first_address_field,
    input wire logic no_pec_setting,
    input wire logic alive_byte_enable,
    input wire logic address_unlock_set,
    input wire logic pec_alert_clr,
    input wire logic [7:0] alert_status,
    output logic [4:0] device_address_field,
    output logic address_unlock_bit,
    output logic pec_alert_bit,
    // register map port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wr_data,
    output logic reg_wr_en,
    input wire logic [15:0] reg_rd_data,
    input wire logic reg_addr_ok
);
    // ************************************************
    // reset release
    // ************************************************
    logic [1:0] rst_sync_r;
    logic rs_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rs_n = rst_sync_r[1];

    // ************************************************
    // state and checksum steps
    // ************************************************
    dcce_state_type s, n;
    logic [7:0] crc_rx_o;
    logic [7:0] crc_tx_o;

    dcce_crc8 u_crc_rx (
        .crc_i(s.rx_crc),
        .byte_i(rx_byte),
        .crc_o(crc_rx_o)
    );

    // runs one byte behind on what was actually sent
    dcce_crc8 u_crc_tx (
        .crc_i(s.tx_crc),
        .byte_i(s.tx_byte),
        .crc_o(crc_tx_o)
    );

    logic s_rd, s_wr, s_chk;
    assign s_rd = s.kind inside {K_BRD, K_URD, K_POLL};
    assign s_wr = s.kind inside {K_BWR, K_UWR};
    assign s_chk = s_rd || s_wr;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [7:0] p;
        logic [7:0] b;
        logic [7:0] src;
        logic [7:0] out;
        logic pass_now;
        logic bad;
        p = s.pos;
        b = rx_byte;
        src = b;
        out = b;
        pass_now = s.pass || rx_code_err;
        bad = 1'b0;
        n = s;
        n.tx_sof = rx_sof;
        n.tx_eof = rx_eof;
        n.tx_valid = 1'b0;
        n.tx_err = rx_code_err;
        n.wr = 1'b0;
        if (pec_alert_clr) begin
            n.pec_alert = 1'b0;
        end
        if (rx_sof) begin
            n.in_frame = 1'b1;
            n.pos = 8'h00;
            n.kind = K_NONE;
            n.pass = 1'b0;
            n.shift = 1'b0;
            n.pec_bad = 1'b0;
            n.tx_acc = 1'b0;
            n.ins_pos = POS_NONE;
            n.dc_pos = POS_NONE;
            n.rpec_pos = POS_NONE;
            n.rx_crc = CRC_INIT;
            n.tx_crc = CRC_INIT;
        end
        // a coding error ends all rewriting for this frame except the assignment address byte
        if (rx_code_err) begin
            n.pass = 1'b1;
        end
        if (rx_valid && s.in_frame) begin
            n.dly0 = b;
            n.dly1 = s.dly0;
            if (s.tx_acc) begin
                n.tx_crc = crc_tx_o;
            end
            if (p < s.rpec_pos) begin
                n.rx_crc = crc_rx_o;
            end
            if (p == 8'h00) begin
                if (b == CMD_ASSIGN && s.unlock) begin
                    n.kind = K_ASSIGN; // unlocked: take the assignment
                end else if (b == CMD_BWR) begin
                    n.kind = K_BWR;
                    n.rpec_pos = POS_WPEC;
                end else if (b == CMD_BRD) begin
                    n.kind = K_BRD;
                    n.ins_pos = POS_RD_INS;
                    n.dc_pos = 8'({2'b00, 5'(s.dev_addr
                        - first_address_field), 1'b0}) + POS_RD_DC0;
                    n.rpec_pos = 8'(n.dc_pos - 8'h01);
                end else if (b == CMD_POLL) begin
                    n.kind = K_POLL;
                    n.regb = ADDR_REG_IDX;
                    n.ins_pos = 8'({2'b00, s.dev_addr, 1'b0}) + 8'h01;
                    n.dc_pos = POS_POLL_DC;
                    n.rpec_pos = POS_POLL_DC + 8'h01;
                end else if (b[7:3] == s.dev_addr && b[2:0] == UWR_LOW) begin
                    n.kind = K_UWR;
                    n.rpec_pos = POS_WPEC;
                end else if (b[7:3] == s.dev_addr && b[2:0] == URD_LOW) begin
                    n.kind = K_URD;
                    n.ins_pos = POS_RD_INS;
                    n.dc_pos = POS_RD_DC0;
                    n.rpec_pos = POS_RD_DC0 - 8'h01;
                end else begin
                    n.kind = K_NONE; // other address: pass along
                end
            end else begin
                if (p == 8'h01 && s.kind != K_POLL) begin
                    n.regb = b;
                end
                if (s.kind == K_ASSIGN && p == POS_ADDR) begin
                    n.dev_addr = b[4:0];
                    n.unlock = 1'b0;
                    out = {3'b000, 5'(b[4:0] + 5'h01)};
                end
                // checksum compare; a write with no-PEC set skips it
                if (p == s.rpec_pos && s_chk
                        && !(s_wr && no_pec_setting)) begin
                    bad = (b != s.rx_crc);
                    n.pec_bad = bad;
                    if (bad) begin
                        n.pec_alert = 1'b1;
                    end
                end
                if (s_wr) begin
                    if (p == POS_LSB) begin
                        n.data[7:0] = b;
                    end
                    if (p == POS_MSB) begin
                        n.data[15:8] = b;
                    end
                    if (p == POS_WPEC && !no_pec_setting && !bad
                            && reg_addr_ok) begin
                        n.wr = 1'b1;
                    end
                    if (p == POS_WALIVE && alive_byte_enable && !pass_now) begin
                        out = 8'(b + 8'h01);
                    end
                end
                if (s_rd && !pass_now) begin
                    if (p == s.ins_pos) begin
                        if (reg_addr_ok) begin
                            n.data = reg_rd_data;
                            out = reg_rd_data[7:0];
                            n.shift = (s.kind != K_POLL);
                        end else begin
                            n.pass = 1'b1;
                        end
                    end else if (p == 8'(s.ins_pos + 8'h01)) begin
                        out = s.data[15:8];
                    end else begin
                        // received words trail own word by two bytes
                        src = s.shift ? s.dly1 : b;
                        out = src;
                        if (p == s.dc_pos) begin
                            out = src | alert_status;
                            out[DC_PEC_BIT] = src[DC_PEC_BIT]
                                | alert_status[DC_PEC_BIT]
                                | s.pec_bad;
                        end else if (p == 8'(s.dc_pos + 8'h01)) begin
                            out = crc_tx_o;
                        end else if (p == 8'(s.dc_pos + 8'h02)
                                && alive_byte_enable) begin
                            out = 8'(src + 8'h01);
                        end
                    end
                end
            end
            n.tx_acc = (n.kind inside {K_BRD, K_URD, K_POLL})
                && !pass_now && (p <= n.dc_pos);
            n.pos = (p == 8'hFF) ? p : 8'(p + 8'h01);
            n.tx_valid = 1'b1;
            n.tx_byte = out;
        end
        // the last two fill bytes stay in the delay line: one pair fewer
        if (rx_eof && s.in_frame) begin
            n.in_frame = 1'b0;
            if (s_wr && no_pec_setting && reg_addr_ok
                    && s.pos > POS_MSB) begin
                n.wr = 1'b1;
            end
        end
        if (address_unlock_set) begin
            n.unlock = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rs_n) begin
        if (!rs_n) begin
            s <= '0;
            s.unlock <= UNLOCK_RST;
        end else begin
            s <= n;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign tx_sof = s.tx_sof;
    assign tx_valid = s.tx_valid;
    assign tx_byte = s.tx_byte;
    assign tx_eof = s.tx_eof;
    assign tx_code_err = s.tx_err;
    assign device_address_field = s.dev_addr;
    assign address_unlock_bit = s.unlock;
    assign pec_alert_bit = s.pec_alert;
    assign reg_addr = s.regb;
    assign reg_wr_data = s.data;
    assign reg_wr_en = s.wr;

    dcce_down_path u_down (
        .clk(clk),
        .rs_n(rs_n),
        .loopback_en(loopback_en),
        .up_sof(s.tx_sof),
        .up_valid(s.tx_valid),
        .up_byte(s.tx_byte),
        .up_eof(s.tx_eof),
        .dn_rx_sof(dn_rx_sof),
        .dn_rx_valid(dn_rx_valid),
        .dn_rx_byte(dn_rx_byte),
        .dn_rx_eof(dn_rx_eof),
        .dn_tx_sof(dn_tx_sof),
        .dn_tx_valid(dn_tx_valid),
        .dn_tx_byte(dn_tx_byte),
        .dn_tx_eof(dn_tx_eof)
    );

    // ************************************************
    // checks
    // ************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rs_n);

    logic rxb;
    assign rxb = rx_valid && s.in_frame;

    sequence assign_byte;
        rxb && s.kind == K_ASSIGN && s.pos == POS_ADDR;
    endsequence

    sequence good_wpec;
        rxb && s_wr && s.pos == POS_WPEC && !no_pec_setting
        && rx_byte == s.rx_crc && reg_addr_ok;
    endsequence

    a_assign_incr: assert property (assign_byte |=>
        tx_byte[4:0] == 5'($past(rx_byte[4:0]) + 5'h01))
        else $error("address byte not incremented");
    a_lock_clear: assert property (assign_byte ##0 !address_unlock_set
        |=> !address_unlock_bit)
        else $error("unlock bit not cleared");
    a_write_commit: assert property (good_wpec |=> reg_wr_en)
        else $error("valid write not committed");
    a_bad_pec_nowr: assert property (rxb && s_wr && s.pos == POS_WPEC
        && !no_pec_setting && rx_byte != s.rx_crc
        |=> !reg_wr_en && tx_byte == $past(rx_byte) && pec_alert_bit)
        else $error("bad write checksum mishandled");
    a_pec_alert_set: assert property (rxb && s_chk && !s_wr
        && s.pos == s.rpec_pos && rx_byte != s.rx_crc
        |=> pec_alert_bit ##0 s.pec_bad)
        else $error("checksum alert not raised");
    a_dc_merge: assert property (rxb && s_rd && !s.pass && !rx_code_err
        && s.pos == s.dc_pos
        |=> (tx_byte & $past(alert_status)) == $past(alert_status))
        else $error("alert status missing in check byte");
    a_alive_inc: assert property (rxb && s.kind == K_BWR && !s.pass
        && !rx_code_err && s.pos == POS_WALIVE && alive_byte_enable
        |=> tx_byte == 8'($past(rx_byte) + 8'h01))
        else $error("alive byte not incremented");
    a_code_err_pass: assert property (rx_code_err ##1 rxb
        |=> tx_byte == $past(rx_byte))
        else $error("rewrite after coding error");
    a_foreign_pass: assert property (rxb && s.pos != 8'h00
        && s.kind == K_NONE |=> tx_valid && tx_byte == $past(rx_byte))
        else $error("foreign packet altered");
    a_own_word: assert property (rxb && s.kind == K_BRD && !s.pass
        && !rx_code_err && s.pos == POS_RD_INS && reg_addr_ok
        |=> tx_byte == $past(reg_rd_data[7:0]))
        else $error("own word not inserted");
    a_err_copy: assert property (rx_code_err |=> tx_code_err)
        else $error("coding error not forwarded");
endmodule

// ===== tb/dcce_chain_model.sv
/*
 * Chain-side model: register map behind one engine and a capture of
 * both byte streams that the engine sends.
 * Assumes the engine's clock; the bench reads the captures by name.
 */
`timescale 1ns/1ns
module dcce_chain_model
    import dcce_pkg::*;
(
    // clock
    input wire logic clk,
    // register map port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr_en,
    output logic [15:0] reg_rd_data,
    output logic reg_addr_ok,
    // streams leaving the engine
    input wire logic tx_sof,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic dn_tx_sof,
    input wire logic dn_tx_valid,
    input wire logic [7:0] dn_tx_byte
);
    logic [7:0] seen[$];
    logic [7:0] dn[$];
    logic [15:0] wr_word = 16'h0000;
    logic [7:0] wr_at = 8'h00;
    int wr_count = 0;
    // upper part unmapped so a refused write can be seen
    assign reg_addr_ok = reg_addr < 8'h40;
    assign reg_rd_data = {reg_addr, ~reg_addr};
    always @(posedge clk) begin
        if (tx_sof)
            seen.delete();
        if (tx_valid)
            seen.push_back(tx_byte);
        if (dn_tx_sof)
            dn.delete();
        if (dn_tx_valid)
            dn.push_back(dn_tx_byte);
        if (reg_wr_en) begin
            wr_word = reg_wr_data;
            wr_at = reg_addr;
            wr_count++;
        end
    end
endmodule

// ===== tb/daisy_chain_command_engine_bench.sv
/*
 * Self-checking bench for the chain command engine: frames enter on
 * the lower receiver, the chain model captures what leaves.
 * Assumes one device at address 3 in a chain starting at address 0.
 */
`timescale 1ns/1ns
module daisy_chain_command_engine_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_sof = 1'b0, rx_valid = 1'b0, rx_eof = 1'b0, rx_code_err = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic no_pec_setting = 1'b0, address_unlock_set = 1'b0;
    logic pec_alert_clr = 1'b0, loopback_en = 1'b0, alive_byte_enable = 1'b1;
    logic tx_sof, tx_valid, tx_eof, tx_code_err;
    logic dn_tx_sof, dn_tx_valid, dn_tx_eof;
    logic address_unlock_bit, pec_alert_bit, reg_wr_en, reg_addr_ok;
    logic [7:0] tx_byte, dn_tx_byte, reg_addr;
    logic [4:0] device_address_field;
    logic [15:0] reg_wr_data, reg_rd_data;
    int fail_count = 0, samples_checked = 0, cycles = 0;

    always #25 clk = ~clk;

    // down path fed with the lower receiver stream so its pass-through shows
    dcce_engine dcce_engine_inst (.clk, .rst_n, .rx_sof, .rx_valid,
        .rx_byte, .rx_eof, .rx_code_err, .tx_sof, .tx_valid, .tx_byte,
        .tx_eof, .tx_code_err, .loopback_en, .dn_rx_sof(rx_sof),
        .dn_rx_valid(rx_valid), .dn_rx_byte(rx_byte), .dn_rx_eof(rx_eof),
        .dn_tx_sof, .dn_tx_valid, .dn_tx_byte, .dn_tx_eof,
        .first_address_field(5'h00), .no_pec_setting,
        .alive_byte_enable, .address_unlock_set, .pec_alert_clr,
        .alert_status(8'h02), .device_address_field, .address_unlock_bit,
        .pec_alert_bit, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_data,
        .reg_addr_ok);
    dcce_chain_model dcce_chain_model_inst (.clk, .reg_addr, .reg_wr_data,
        .reg_wr_en, .reg_rd_data, .reg_addr_ok, .tx_sof, .tx_valid,
        .tx_byte, .dn_tx_sof, .dn_tx_valid, .dn_tx_byte);

    // ********************************
    // shared tasks
    // ********************************
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // bench's own checksum, poly 07h, init 00h, msb first
    function automatic logic [7:0] crc(input logic [7:0] q[$], input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            c = c ^ q[i];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    task automatic run(input logic [7:0] q[$], input int ce);
        @(negedge clk) rx_sof = 1'b1;
        @(negedge clk) rx_sof = 1'b0;
        foreach (q[i]) begin
            rx_valid = 1'b1;
            rx_byte = q[i];
            rx_code_err = (i == ce);
            @(negedge clk);
        end
        rx_valid = 1'b0;
        rx_code_err = 1'b0;
        rx_eof = 1'b1;
        @(negedge clk) rx_eof = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic cmpq(input logic [7:0] e[$]);
        chk("count", 16'(dcce_chain_model_inst.seen.size()), 16'(e.size()));
        foreach (e[i])
            chk("byte", 16'(dcce_chain_model_inst.seen[i]), 16'(e[i]));
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_assign();
        run('{8'h57, 8'h00, 8'h03}, -1);
        cmpq('{8'h57, 8'h00, 8'h04});
        chk("dn", 16'(dcce_chain_model_inst.dn[2]), 16'h0003);
        chk("da", 16'(device_address_field), 16'h0003);
        chk("unlock", 16'(address_unlock_bit), 16'h0000);
        run('{8'h57, 8'h00, 8'h09}, -1);
        cmpq('{8'h57, 8'h00, 8'h09});
        chk("da", 16'(device_address_field), 16'h0003);
        @(negedge clk) address_unlock_set = 1'b1;
        @(negedge clk) address_unlock_set = 1'b0;
        chk("unlock", 16'(address_unlock_bit), 16'h0001);
        loopback_en = 1'b1;
        run('{8'h57, 8'h00, 8'h03}, -1);
        chk("loop", 16'(dcce_chain_model_inst.dn[2]), 16'h0004);
        loopback_en = 1'b0;
    endtask

    task automatic t_write(input logic [7:0] cmd, input logic [7:0] ra,
                           input logic bad, input int bump);
        logic [7:0] q[$];
        int n;
        q = '{cmd, ra, 8'h34, 8'h56};
        q.push_back(crc(q, 4) ^ {bad, 7'h00});
        q.push_back(8'hFF);
        n = dcce_chain_model_inst.wr_count;
        run(q, -1);
        q[5] = q[5] + 8'(bump);
        cmpq(q);
        chk("alert", 16'(pec_alert_bit), 16'(bad));
        chk("wrs", 16'(dcce_chain_model_inst.wr_count - n),
            16'(bump != 0 && !bad && ra < 8'h40));
        if (bump != 0 && !bad && ra < 8'h40) begin
            chk("word", dcce_chain_model_inst.wr_word, 16'h5634);
            chk("at", 16'(dcce_chain_model_inst.wr_at), 16'(ra));
        end
        @(negedge clk) pec_alert_clr = 1'b1;
        @(negedge clk) pec_alert_clr = 1'b0;
    endtask

    task automatic t_no_pec_setting();
        no_pec_setting = 1'b1;
        alive_byte_enable = 1'b0;
        run('{8'h02, 8'h21, 8'hAA, 8'h55, 8'h00, 8'hFF}, -1);
        cmpq('{8'h02, 8'h21, 8'hAA, 8'h55, 8'h00, 8'hFF});
        chk("word", dcce_chain_model_inst.wr_word, 16'h55AA);
        no_pec_setting = 1'b0;
        alive_byte_enable = 1'b1;
    endtask

    task automatic t_read(input logic bad);
        logic [7:0] i[$];
        logic [7:0] o[$];
        i = '{8'h03, 8'h11, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'h10};
        i.push_back(crc(i, 9) ^ {bad, 7'h00});
        i = {i, 8'h05, 8'hC2, 8'hD3};
        o = '{8'h03, 8'h11, 8'hEE, 8'h11, 8'hA1, 8'hA2, 8'hA3, 8'hA4};
        o = {o, 8'hA5, 8'hA6, 8'h12 | {bad, 7'h00}};
        o = {o, crc(o, 11), 8'h06};
        run(i, -1);
        cmpq(o);
        chk("alert", 16'(pec_alert_bit), 16'(bad));
        @(negedge clk) pec_alert_clr = 1'b1;
        @(negedge clk) pec_alert_clr = 1'b0;
    endtask

    task automatic t_unicast_read();
        logic [7:0] i[$];
        logic [7:0] o[$];
        i = '{8'h1D, 8'h11, 8'h10};
        i = {i, crc(i, 3), 8'h05, 8'hC2, 8'hD3};
        o = '{8'h1D, 8'h11, 8'hEE, 8'h11, 8'h12};
        o = {o, crc(o, 5), 8'h06};
        run(i, -1);
        cmpq(o);
        run(i, 1);
        cmpq(i);
    endtask

    task automatic t_poll();
        logic [7:0] i[$];
        logic [7:0] o[$];
        i = '{8'h01};
        for (int k = 0; k < 32; k++)
            i = {i, 8'hC2, 8'hD3};
        i.push_back(8'h00);
        i = {i, crc(i, 66), 8'h09};
        o = i;
        o[7] = 8'hFF;
        o[8] = 8'h00;
        o[65] = 8'h02;
        o[66] = crc(o, 66);
        o[67] = 8'h0A;
        run(i, -1);
        cmpq(o);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_assign();
        t_write(8'h02, 8'h12, 1'b0, 1);
        t_write(8'h02, 8'h12, 1'b1, 1);
        t_write(8'h2C, 8'h12, 1'b0, 0);
        t_write(8'h1C, 8'h80, 1'b0, 1);
        t_write(8'h1C, 8'h20, 1'b0, 1);
        t_no_pec_setting();
        t_read(1'b0);
        t_read(1'b1);
        t_unicast_read();
        t_poll();
        summarize();
    end
endmodule
